// >>> cycle_timer.sv
// counts out the cycle budget of one load access
// assumes start is a one-cycle pulse and cycles is at least one
`default_nettype none
module cycle_timer (
  input  wire logic ref_clk,  // core clock
  input  wire logic reset_n,  // async reset, active low
  load_mem_if.timer tmr       // start, budget and done
);
  logic [3:0] count_q;  // cycles remaining
  // ************************************************************
  // countdown
  // ************************************************************
  // load budget on start, count to one, pulse done
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 4'h0;
    end else if (tmr.start) begin
      count_q <= tmr.cycles;
    end else if (count_q != 4'h0) begin
      count_q <= count_q - 4'h1;
    end
  end
  assign tmr.done = (count_q == 4'h1) && !tmr.start;  // last cycle of budget
endmodule : cycle_timer
`default_nettype wire

// >>> load_exec.sv
// execution unit for mapped register, product high and status loads
// assumes instruction words arrive with a valid strobe; memory read is combinational
`default_nettype none
module load_exec (
  input  wire logic        ref_clk,         // core clock
  input  wire logic        reset_n,         // async reset, active low
  input  wire logic        instr_valid,     // instruction word present
  input  wire logic [15:0] instr_word,      // instruction or second word
  output logic             instr_ready,     // block accepts a word
  input  wire logic [15:0] aux_reg_value,   // current aux register contents
  input  wire logic [8:0]  data_page_in,    // current data page pointer
  input  wire logic [15:0] repeat_count,    // repeat count, 0 means single
  input  wire logic        same_sa_block,   // operand and code share a block
  input  wire logic [3:0]  io_wait_states,  // destination io window waits
  input  wire logic [3:0]  code_wait_states,// external code waits
  output logic [15:0]      mem_addr,        // data memory read address
  input  wire logic [15:0] mem_rdata,       // data memory read data
  output logic             mapped_we,       // mapped register write pulse
  output logic [15:0]      mapped_waddr,    // mapped register address
  output logic [15:0]      mapped_wdata,    // mapped register data
  output logic [31:0]      product_q,       // product register
  output logic [15:0]      status_zero_q,   // status word zero
  output logic [15:0]      status_one_q,    // status word one
  output logic [2:0]       aux_select_q,    // aux pointer select
  output logic             busy             // execution in progress
);
  // ************************************************************
  // decode helpers
  // ************************************************************
  typedef enum logic [1:0] {none_op_s, mapped_op_s, product_op_s, status_op_s} op_kind_type;
  // classify an upper byte
  function automatic op_kind_type classify(input logic [7:0] upper);
    op_kind_type k;
    k = none_op_s;
    if (upper == load_exec_pkg::OP_MAPPED_LOAD) k = mapped_op_s;
    else if (upper == load_exec_pkg::OP_PRODUCT_HIGH) k = product_op_s;
    else if (upper == load_exec_pkg::OP_STATUS_ZERO || upper == load_exec_pkg::OP_STATUS_ONE) k = status_op_s;
    return k;
  endfunction : classify
  // operand address from direct offset or aux register
  function automatic logic [15:0] operand_addr(input logic [15:0] iw, input logic [8:0] dp,
                                               input logic [15:0] ar);
    logic [15:0] a;
    a = iw[load_exec_pkg::IND_BIT] ? ar : {dp, iw[6:0]};
    return a;
  endfunction : operand_addr
  // ************************************************************
  // state
  // ************************************************************
  load_exec_pkg::exec_state_type state_q;  // sequencer state
  op_kind_type  kind_q;                     // latched instruction kind
  logic [15:0]  first_q;                    // latched first word
  logic [15:0]  src_q;                      // source address
  logic [15:0]  dst_q;                      // operand address
  logic [15:0]  iter_q;                     // iterations remaining
  op_kind_type  kind_now;                   // decode of incoming word
  logic [15:0]  opnd_addr;                  // operand address of incoming word
  logic         periph_dst;                 // peripheral destination
  logic         io_dst;                     // io window destination
  load_mem_if   mif ();                     // timer link
  cycle_timer u_timer (.ref_clk(ref_clk), .reset_n(reset_n), .tmr(mif));
  assign kind_now = classify(instr_word[15:8]);
  // formed once so the mapped path can slice it
  assign opnd_addr = operand_addr(instr_word, data_page_in, aux_reg_value);
  assign busy = (state_q != load_exec_pkg::idle_type_s);
  assign instr_ready = (state_q == load_exec_pkg::idle_type_s) || (state_q == load_exec_pkg::fetch2_s);
  // destination class from the low seven address bits
  assign periph_dst = dst_q[6:0] >= load_exec_pkg::PERIPH_BASE && dst_q[6:0] < load_exec_pkg::IO_WINDOW_BASE;
  assign io_dst     = dst_q[6:0] >= load_exec_pkg::IO_WINDOW_BASE;
  // ************************************************************
  // cycle budget
  // ************************************************************
  // per-access cycle count from destination and memory placement
  always_comb begin
    logic [3:0] c;
    c = load_exec_pkg::SINGLE_CYC;
    // in idle only a one-word load can start: a stale mapped kind must not leak in
    if (state_q != load_exec_pkg::idle_type_s && kind_q == mapped_op_s) begin
      if (io_dst) begin
        c = load_exec_pkg::MAPPED_PORT_CYC + io_wait_states;
      end else begin
        c = load_exec_pkg::MAPPED_CORE_CYC;
        if (periph_dst) c = c + load_exec_pkg::EXTRA_CYC;
      end
    end
    if (same_sa_block) c = c + load_exec_pkg::EXTRA_CYC;
    c = c + code_wait_states;  // external code penalty
    // restart cycle counts as the first cycle of the next repeat
    if (state_q == load_exec_pkg::done_s) c = c - 4'h1;
    mif.cycles = c;
  end
  assign mif.start = (state_q == load_exec_pkg::fetch2_s && instr_valid)
                   || (state_q == load_exec_pkg::idle_type_s && instr_valid && kind_now != mapped_op_s
                       && kind_now != none_op_s)
                   || (state_q == load_exec_pkg::done_s);
  // ************************************************************
  // sequencer
  // ************************************************************
  // idle -> (fetch2) -> run -> done loops for repeats
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= load_exec_pkg::idle_type_s;
      kind_q  <= none_op_s;
      first_q <= 16'h0000;
      iter_q  <= 16'h0000;
      dst_q   <= 16'h0000;
    end else begin
      case (state_q)
        load_exec_pkg::idle_type_s: begin
          if (instr_valid && kind_now != none_op_s) begin
            kind_q  <= kind_now;
            first_q <= instr_word;
            iter_q  <= repeat_count;
            if (kind_now == mapped_op_s) begin
              // keep low seven bits, zero the upper nine
              dst_q <= {{load_exec_pkg::PAGE_BITS{1'b0}}, opnd_addr[load_exec_pkg::MAPPED_BITS-1:0]};
              state_q <= load_exec_pkg::fetch2_s;
            end else begin
              dst_q   <= opnd_addr;
              state_q <= load_exec_pkg::run_s;
            end
          end
        end
        load_exec_pkg::fetch2_s: begin
          if (instr_valid) state_q <= load_exec_pkg::run_s;  // second word taken
        end
        load_exec_pkg::run_s: begin
          if (mif.done) begin
            if (kind_q == mapped_op_s && iter_q != 16'h0000) begin
              iter_q  <= iter_q - 16'h0001;
              state_q <= load_exec_pkg::done_s;  // next repeat iteration
            end else begin
              state_q <= load_exec_pkg::idle_type_s;
            end
          end
        end
        load_exec_pkg::done_s: begin
          state_q <= load_exec_pkg::run_s;  // restart timer for repeat
        end
        default: begin
          state_q <= load_exec_pkg::idle_type_s;
        end
      endcase
    end
  end
  // ************************************************************
  // source address
  // ************************************************************
  // full 16-bit source, bumped after each repeated load
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_q <= 16'h0000;
    end else if (state_q == load_exec_pkg::fetch2_s && instr_valid) begin
      src_q <= instr_word;
    end else if (state_q == load_exec_pkg::run_s && mif.done && kind_q == mapped_op_s) begin
      src_q <= src_q + 16'h0001;
    end
  end
  assign mem_addr = (kind_q == mapped_op_s) ? src_q : dst_q;
  // ************************************************************
  // mapped register write
  // ************************************************************
  // one write per completed access
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mapped_we    <= 1'b0;
      mapped_waddr <= 16'h0000;
      mapped_wdata <= 16'h0000;
    end else begin
      mapped_we <= (state_q == load_exec_pkg::run_s) && mif.done && (kind_q == mapped_op_s);
      if ((state_q == load_exec_pkg::run_s) && mif.done && (kind_q == mapped_op_s)) begin
        mapped_waddr <= dst_q;
        mapped_wdata <= mem_rdata;
      end
    end
  end
  // ************************************************************
  // product register
  // ************************************************************
  // upper half only; lower half kept
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      product_q <= 32'h0000_0000;
    end else if (state_q == load_exec_pkg::run_s && mif.done && kind_q == product_op_s) begin
      product_q <= {mem_rdata, product_q[15:0]};
    end
  end
  // ************************************************************
  // status registers and aux pointer
  // ************************************************************
  // status load; mapped load never touches page pointer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_zero_q <= load_exec_pkg::STATUS_ZERO_RESET;
      status_one_q  <= load_exec_pkg::STATUS_ONE_RESET;
      aux_select_q  <= 3'h0;
    end else if (state_q == load_exec_pkg::run_s && mif.done) begin
      case (kind_q)
        status_op_s: begin
          aux_select_q <= mem_rdata[load_exec_pkg::POINTER_LSB +: 3];
          if (first_q[8]) begin
            status_one_q <= mem_rdata;  // buffer field loads with word
          end else begin
            // mask bit kept, status one buffer untouched
            status_zero_q <= {mem_rdata[15:load_exec_pkg::MASK_BIT+1],
                              status_zero_q[load_exec_pkg::MASK_BIT],
                              mem_rdata[load_exec_pkg::DPP_MSB:0]};
          end
        end
        mapped_op_s: begin
          status_zero_q <= status_zero_q;
        end
        default: begin
          aux_select_q <= aux_select_q;
        end
      endcase
    end
  end
endmodule : load_exec
`default_nettype wire

// >>> load_exec_chk.sv
// concurrent checks on the load unit top ports
// assumes one clock and async active-low reset
`default_nettype none
module load_exec_chk (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        instr_ready,
  input wire logic [15:0] aux_reg_value,
  input wire logic        busy,
  input wire logic        mapped_we,
  input wire logic [15:0] mapped_waddr,
  input wire logic [31:0] product_q,
  input wire logic [15:0] status_zero_q,
  input wire logic [15:0] status_one_q,
  input wire logic [2:0]  aux_select_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic       taken;  // mapped opcode accepted in idle
  logic [6:0] tgt_q;  // target captured at acceptance
  assign taken = instr_valid && instr_ready && !busy && instr_word[15:8] == load_exec_pkg::OP_MAPPED_LOAD;
  // remember the low target bits from the direct or indirect address
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) tgt_q <= 7'h00;
    else if (taken) tgt_q <= instr_word[7] ? aux_reg_value[6:0] : instr_word[6:0];
  end
  sequence issue_s; taken; endsequence
  sequence source_s; instr_valid && instr_ready; endsequence
  upper_zero_a: assert property (mapped_we |-> mapped_waddr[15:7] == 9'h000)
    else $error("mapped target upper bits not zero");
  target_low_a: assert property (mapped_we |-> mapped_waddr[6:0] == tgt_q)
    else $error("mapped target low bits wrong");
  write_due_a: assert property (issue_s ##1 source_s |-> ##[2:60] mapped_we)
    else $error("mapped write missing");
  pulse_one_a: assert property (mapped_we |=> !mapped_we)
    else $error("mapped write longer than one cycle");
  page_kept_a: assert property (mapped_we |-> $stable(status_zero_q[8:0]))
    else $error("page pointer changed by mapped load");
  low_half_a: assert property ($stable(product_q[15:0]))
    else $error("product low half changed");
  mask_kept_a: assert property ($stable(status_zero_q[9]))
    else $error("interrupt mask changed");
  buffer_kept_a: assert property ($changed(status_zero_q) |-> $stable(status_one_q))
    else $error("status one changed by status zero load");
  ptr_load_a: assert property ($changed(status_one_q) |-> aux_select_q == status_one_q[15:13])
    else $error("aux pointer not taken from word");
endmodule : load_exec_chk
bind load_exec load_exec_chk chk (.ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .aux_reg_value(aux_reg_value), .busy(busy),
  .mapped_we(mapped_we), .mapped_waddr(mapped_waddr), .product_q(product_q), .status_zero_q(status_zero_q),
  .status_one_q(status_one_q), .aux_select_q(aux_select_q));
`default_nettype wire

// >>> load_exec_pkg.sv
// constants, opcodes and states for the load execution block
// assumes a single core clock and an async active-low reset
`default_nettype none
package load_exec_pkg;
  // ************************************************************
  // opcode upper bytes
  // ************************************************************
  localparam logic [7:0] OP_MAPPED_LOAD  = 8'h89;  // mapped register load, first word
  localparam logic [7:0] OP_PRODUCT_HIGH = 8'h75;  // product high load
  localparam logic [7:0] OP_STATUS_ZERO  = 8'h0E;  // status word zero load
  localparam logic [7:0] OP_STATUS_ONE   = 8'h0F;  // status word one load
  localparam int         IND_BIT         = 7;      // direct/indirect select bit
  // ************************************************************
  // address and field layout
  // ************************************************************
  localparam int         MAPPED_BITS     = 7;      // low bits kept for mapped target
  localparam int         PAGE_BITS       = 9;      // upper bits forced to zero
  localparam int         POINTER_LSB     = 13;     // aux pointer field in loaded word
  localparam int         MASK_BIT        = 9;      // global interrupt mask in status zero
  localparam int         DPP_MSB         = 8;      // data page pointer top bit
  localparam logic [15:0] STATUS_ZERO_RESET = 16'h0600; // status zero after reset
  localparam logic [15:0] STATUS_ONE_RESET  = 16'h0000; // status one after reset
  localparam logic [6:0] PERIPH_BASE     = 7'h20;  // first peripheral mapped register
  localparam logic [6:0] IO_WINDOW_BASE  = 7'h50;  // first mapped io window location
  // ************************************************************
  // cycle counts
  // ************************************************************
  localparam logic [3:0] MAPPED_CORE_CYC = 4'h2;   // base mapped load cycles
  localparam logic [3:0] MAPPED_PORT_CYC = 4'h3;   // base mapped io window cycles
  localparam logic [3:0] SINGLE_CYC      = 4'h1;   // base single word load
  localparam logic [3:0] EXTRA_CYC       = 4'h1;   // one-cycle penalty
  typedef enum logic [2:0] {idle_type_s, fetch2_s, run_s, done_s} exec_state_type;
endpackage : load_exec_pkg
`default_nettype wire

// >>> load_exec_tb.sv
// self-checking bench for the load unit with a queue model
// assumes mem_model answers reads combinationally
`default_nettype none
module load_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, same_sa_block = 1'b0;
  logic [15:0] instr_word = 16'h0000, aux_reg_value = 16'h0000, repeat_count = 16'h0000;
  logic [8:0]  data_page_in = 9'h000;
  logic [3:0]  io_wait_states = 4'h0, code_wait_states = 4'h0;
  logic        instr_ready, mapped_we, busy;
  logic [15:0] mem_addr, mem_rdata, mapped_waddr, mapped_wdata, status_zero_q, status_one_q, m_s0, m_s1;
  logic [31:0] product_q, m_prod, exp_w;
  logic [2:0]  aux_select_q, m_aux;
  int          bad_count = 0, n_compared = 0, cyc = 0, we_cnt = 0, first_cyc = 0, l0 = 0, last_cyc = 0;
  integer      seed = 32'h47fb;
  logic [31:0] exp_q[$];  // pending {address, data} of mapped writes
  // variant table: target, same block, io waits, code waits, extra cycles
  logic [6:0]  tg[7] = '{7'h35, 7'h20, 7'h4F, 7'h05, 7'h60, 7'h50, 7'h0A};
  int          sa[7] = '{0, 0, 0, 1, 0, 0, 0}, io[7] = '{0, 0, 0, 0, 3, 0, 0};
  int          cw[7] = '{0, 0, 0, 0, 0, 0, 2}, ex[7] = '{1, 1, 1, 1, 4, 1, 2};
  logic [7:0]  ops[4] = '{load_exec_pkg::OP_PRODUCT_HIGH, load_exec_pkg::OP_STATUS_ZERO,
                          load_exec_pkg::OP_STATUS_ONE, 8'h12};
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc++;
  load_exec dut (.ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .aux_reg_value(aux_reg_value), .data_page_in(data_page_in),
    .repeat_count(repeat_count), .same_sa_block(same_sa_block), .io_wait_states(io_wait_states),
    .code_wait_states(code_wait_states), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mapped_we(mapped_we),
    .mapped_waddr(mapped_waddr), .mapped_wdata(mapped_wdata), .product_q(product_q),
    .status_zero_q(status_zero_q), .status_one_q(status_one_q), .aux_select_q(aux_select_q), .busy(busy));
  mem_model mem (.addr(mem_addr), .rdata(mem_rdata));
  function automatic logic [15:0] mem_f(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'hC3A5;
  endfunction : mem_f
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word
  task automatic chk_cyc(input string what, input int e, input int g);
    n_compared++;
    if (g != e) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_cyc
  // each mapped write is matched against the model queue
  always @(negedge ref_clk) begin
    if (reset_n && mapped_we === 1'b1) begin
      if (we_cnt == 0) first_cyc = cyc;
      last_cyc = cyc;
      we_cnt++;
      exp_w = exp_q.size() != 0 ? exp_q.pop_front() : 32'hFFFF_FFFF;  // stray write if queue empty
      chk_word("mapped write", exp_w, {mapped_waddr, mapped_wdata});
    end
  end
  // present a word and hold it until the edge that takes it
  task automatic send(input logic [15:0] w);
    int k;
    instr_valid = 1'b1;
    instr_word = w;
    k = 0;
    while (instr_ready !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
  endtask : send
  // drop valid, count busy cycles into n, then settle
  task automatic wait_idle(output int n);
    int k;
    instr_valid = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    n = k;
    repeat (3) @(negedge ref_clk);
    chk_cyc("busy release", 1, k < 300);
  endtask : wait_idle
  // extra -1 checks the core reference latency, below -1 gives cycles per repeat
  task automatic mload(input logic [6:0] tgt, input logic ind, input int rep, input int extra);
    logic [15:0] src;
    int t0;
    int n;
    src = 16'($random(seed));
    src[15] = 1'b0;
    aux_reg_value = 16'($random(seed));
    data_page_in = 9'($random(seed));
    repeat_count = 16'(rep);
    if (ind) aux_reg_value[6:0] = tgt;
    for (int i = 0; i <= rep; i++) exp_q.push_back({9'h000, tgt, mem_f(src + 16'(i))});
    we_cnt = 0;
    send({load_exec_pkg::OP_MAPPED_LOAD, ind ? 8'h80 : {1'b0, tgt}});
    t0 = cyc;
    send(src);
    wait_idle(n);
    chk_cyc("write count", rep + 1, we_cnt);
    chk_word("status zero", m_s0, status_zero_q);
    if (extra == -1) begin
      l0 = first_cyc - t0;
      chk_cyc("core latency", 1 + int'(load_exec_pkg::MAPPED_CORE_CYC), l0);
    end else if (extra >= 0) begin
      chk_cyc("mapped latency", l0 + extra, first_cyc - t0);
    end else begin
      chk_cyc("repeat span", rep * (0 - extra), last_cyc - first_cyc);
    end
    $display("test done: mapped load to %h", tgt);
  endtask : mload
  task automatic one_word(input logic [7:0] op, input logic ind);
    logic [15:0] d;
    logic [6:0] dma;
    int e;
    int n;
    dma = 7'($random(seed));
    aux_reg_value = 16'($random(seed));
    data_page_in = 9'($random(seed));
    d = mem_f(ind ? aux_reg_value : {data_page_in, dma});
    // one cycle, two when operand and code share a block; unknown codes take none
    e = (op == load_exec_pkg::OP_PRODUCT_HIGH || op == load_exec_pkg::OP_STATUS_ZERO
         || op == load_exec_pkg::OP_STATUS_ONE) ? 1 + int'(same_sa_block) : 0;
    if (op == load_exec_pkg::OP_PRODUCT_HIGH) m_prod[31:16] = d;
    if (op == load_exec_pkg::OP_STATUS_ZERO) m_s0 = {d[15:10], m_s0[9], d[8:0]};
    if (op == load_exec_pkg::OP_STATUS_ONE) m_s1 = d;
    if (op == load_exec_pkg::OP_STATUS_ZERO || op == load_exec_pkg::OP_STATUS_ONE) m_aux = d[15:13];
    send({op, ind ? 8'h80 : {1'b0, dma}});
    wait_idle(n);
    chk_cyc("load cycles", e, n);
    chk_word("product", m_prod, product_q);
    chk_word("status zero", m_s0, status_zero_q);
    chk_word("status one", m_s1, status_one_q);
    chk_word("aux select", m_aux, aux_select_q);
    $display("test done: opcode %h mode %0d", op, ind);
  endtask : one_word
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    m_prod = 32'h0000_0000;
    m_s0 = load_exec_pkg::STATUS_ZERO_RESET;
    m_s1 = 16'h0000;
    m_aux = 3'h0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    mload(7'h10, 1'b0, 0, -1);
    for (int i = 0; i < 7; i++) begin
      same_sa_block = sa[i][0];
      io_wait_states = 4'(io[i]);
      code_wait_states = 4'(cw[i]);
      mload(tg[i], 1'b0, 0, ex[i]);
    end
    same_sa_block = 1'b0;
    io_wait_states = 4'h0;
    code_wait_states = 4'h0;
    mload(7'h12, 1'b1, 0, 0);
    mload(7'h08, 1'b0, 3, -2);
    mload(7'h2A, 1'b0, 2, -3);
    for (int m = 0; m < 2; m++) begin
      same_sa_block = m[0];
      for (int j = 0; j < 4; j++) one_word(ops[j], m[0]);
    end
    wrap_up();
  end
  // watchdog: the tests need well under ten thousand cycles
  initial begin
    #200000;
    bad_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    wrap_up();
  end
endmodule : load_exec_tb
`default_nettype wire

// >>> load_mem_if.sv
// interface carrying the data memory request between top and timer
// assumes same clock domain as the top module
`default_nettype none
interface load_mem_if;
  logic [3:0] cycles;  // cycles the access occupies
  logic       start;   // start a timed access
  logic       done;    // access finished pulse
  modport owner (output cycles, output start, input done);
  modport timer (input cycles, input start, output done);
endinterface : load_mem_if
`default_nettype wire

// >>> mem_model.sv
// far-side data memory model for the load unit
// assumes reads answer in the same cycle with no wait states
`default_nettype none
module mem_model (
  input  wire logic [15:0] addr,  // read address
  output logic      [15:0] rdata  // stored word
);
  timeunit 1ns;
  timeprecision 1ps;
  // address-dependent pattern: a wrong address returns wrong data
  assign rdata = {addr[7:0], addr[15:8]} ^ 16'hC3A5;
endmodule : mem_model
`default_nettype wire
